// File: common/dodc_defines.svh
`ifndef DODC_DEFINES_SVH
`define DODC_DEFINES_SVH

// Prescaler select codes
`define DODC_PSC_POST_DIVIDER_BYPASS 2'h0
`define DODC_PSC_DIV2 2'h1
`define DODC_PSC_DIV4 2'h2
`define DODC_PSC_DIV8 2'h3
// Post-divider: divisor is field plus this offset
`define DODC_DIV_OFFSET 11'h002
`define DODC_DIV_W 10
// Factory defaults
`define DODC_DEF_ENMODE 1'b1
`define DODC_DEF_SEL 1'b1
`define DODC_DEF_REF_PIN_POWERDOWN_CFG 1'b0
`define DODC_DEF_MAIN_PIN_POWERDOWN_CFG 1'b0
`define DODC_DEF_BYPASS 1'b0
`define DODC_DEF_PSC 2'h0
`define DODC_DEF_DIV 10'h000
// Oscillator settle time in master clock cycles
`define DODC_SETTLE_CYCLES 14'h1f40
`define DODC_CNT_W 14

`endif

// File: common/dodc_pkg.sv
`default_nettype none
package dodc_pkg;
	typedef struct packed {
		logic ref_enable_mode;
		logic ref_source_select;
		logic ref_pin_powerdown_cfg;
		logic main_pin_powerdown_cfg;
		logic post_divider_bypass;
		logic [1:0] ref_prescale_sel;
		logic [1:0] main_prescale_sel;
		logic [9:0] post_div;
	} dodc_cfg_t;

	typedef struct packed {
		logic ref_clk_out;
		logic ref_clk_oe;
		logic main_clk_out;
		logic main_clk_oe;
	} dodc_out_t;

	typedef enum logic [1:0] {
		DODC_ST_SETTLE,
		DODC_ST_RUN,
		DODC_ST_DOWN
	} dodc_state_t;
endpackage
`default_nettype wire

// File: design/dodc_gate.sv
`include "dodc_defines.svh"
`default_nettype none
// Glitch-free output gate: turns on while the clock is low, floats only after the pin has shown low
module dodc_gate (
	input wire logic core_clk,
	input wire logic rst_n,
	// Clock and request
	input wire logic clk_in,
	input wire logic enable,
	// Gated pin
	output logic pin_out,
	output logic pin_oe
);
	logic oe_q;
	logic oe_pin_q;
	logic out_q;
	wire oe_d = clk_in ? oe_q : enable;
	// Pin enable lags a falling gate by one cycle, so the pin is driven low before it floats
	wire oe_pin_d = oe_d | oe_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			oe_q <= 1'b0;
			oe_pin_q <= 1'b0;
			out_q <= 1'b0;
		end else begin
			oe_q <= oe_d;
			oe_pin_q <= oe_pin_d;
			out_q <= clk_in & oe_d;
		end
	end

	assign pin_out = out_q;
	assign pin_oe = oe_pin_q;
endmodule
`default_nettype wire

// File: design/dodc_top.sv
// Overview of operation
// - Reference prescaler divides master clock by 1, 2, 4 or 8.
// - Main prescaler divides by 1, 2, 4 or 8, feeding output or post-divider.
// - Post-divider divides main prescaler output by 2 through 1025.
// - Bypass bit routes main prescaler straight to main output.
// - Reference output mux picks master clock or reference prescaler.
// - Enable-mode 0, select 1: reference pin selects prescaled (high) or master.
// - Enable-mode 1: reference pin high floats reference output; select picks clock.
// - Reference power-down cfg: reference pin high powers down, floats both outputs.
// - All reference bits 0: reference output floats; pin high powers down.
// - Main power-down cfg 0: main pin is main output enable only.
// - Main power-down cfg 1: main pin high powers down whole device.
// - Stored settings load automatically at power-up.
// - External master programs settings over 2-wire bus; device accepts them except while powered down.
// - Prescaler codes 00,01,10,11 give divide 1,2,4,8; default 00.
// - Post-divider divisor equals ten-bit field plus two.
// - Output goes high-impedance only after its clock is low.
// - Outputs stay off about 8000 cycles after power-up or wake.
`include "dodc_defines.svh"
`default_nettype none
module dodc_top
	import dodc_pkg::*;
(
	// Master clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Configuration written by the serial slave
	input wire dodc_pkg::dodc_cfg_t cfg_wdata,
	input wire logic cfg_we,
	// Control pins
	input wire logic ref_control_pin,
	input wire logic main_control_pin,
	// Clock outputs with enables
	output var dodc_pkg::dodc_out_t clk_pins,
	// Status
	output logic powered_down,
	output var dodc_pkg::dodc_cfg_t cfg_rdata
);
	import dodc_pkg::*;

	// ==========================================
	// Configuration store
	localparam dodc_cfg_t CFG_DEFAULT = '{
		ref_enable_mode: `DODC_DEF_ENMODE,
		ref_source_select: `DODC_DEF_SEL,
		ref_pin_powerdown_cfg: `DODC_DEF_REF_PIN_POWERDOWN_CFG,
		main_pin_powerdown_cfg: `DODC_DEF_MAIN_PIN_POWERDOWN_CFG,
		post_divider_bypass: `DODC_DEF_BYPASS,
		ref_prescale_sel: `DODC_DEF_PSC,
		main_prescale_sel: `DODC_DEF_PSC,
		post_div: `DODC_DEF_DIV
	};
	dodc_cfg_t cfg_q;
	dodc_state_t state_q;
	dodc_state_t state_d;
	// Programming is refused while powered down
	wire cfg_load = cfg_we && (state_q != DODC_ST_DOWN);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cfg_q <= CFG_DEFAULT;
		end else if (cfg_load) begin
			cfg_q <= cfg_wdata;
		end
	end

	// ==========================================
	// Control pin synchronisers
	logic [1:0] ref_pin_q;
	logic [1:0] main_pin_q;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ref_pin_q <= 2'h0;
			main_pin_q <= 2'h0;
		end else begin
			ref_pin_q <= {ref_pin_q[0], ref_control_pin};
			main_pin_q <= {main_pin_q[0], main_control_pin};
		end
	end
	wire ref_pin = ref_pin_q[1];
	wire main_pin = main_pin_q[1];

	// ==========================================
	// Prescalers: free-running counter, tap per code
	logic [2:0] psc_cnt_q;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			psc_cnt_q <= 3'h0;
		end else begin
			psc_cnt_q <= psc_cnt_q + 3'h1;
		end
	end
	// Divide-by-1 is represented as an every-cycle tick; others by counter taps
	function automatic logic psc_tick(input logic [1:0] sel, input logic [2:0] cnt);
		logic t;
		t = 1'b0;
		case (sel)
			`DODC_PSC_POST_DIVIDER_BYPASS: t = 1'b1;
			`DODC_PSC_DIV2: t = (cnt[0] == 1'b1);
			`DODC_PSC_DIV4: t = (cnt[1:0] == 2'h3);
			default: t = (cnt == 3'h7);
		endcase
		return t;
	endfunction
	wire ref_tick = psc_tick(cfg_q.ref_prescale_sel, psc_cnt_q);
	wire main_tick = psc_tick(cfg_q.main_prescale_sel, psc_cnt_q);

	// Prescaled clock levels (toggle halves the tick rate; prescale code 0 passes master)
	logic ref_tgl_q;
	logic main_tgl_q;
	logic master_q;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ref_tgl_q <= 1'b0;
			main_tgl_q <= 1'b0;
			master_q <= 1'b0;
		end else begin
			master_q <= ~master_q;
			if (ref_tick) begin
				ref_tgl_q <= ~ref_tgl_q;
			end
			if (main_tick) begin
				main_tgl_q <= ~main_tgl_q;
			end
		end
	end
	wire ref_psc_clk = ref_tgl_q;
	wire main_psc_clk = main_tgl_q;

	// ==========================================
	// Post-divider: counts main prescaler rising edges
	logic main_psc_d1_q;
	logic [10:0] post_cnt_q;
	logic post_clk_q;
	wire main_rise = main_psc_clk & ~main_psc_d1_q;
	wire [10:0] divisor = {1'b0, cfg_q.post_div} + `DODC_DIV_OFFSET;
	wire [10:0] half_lo = {1'b0, divisor[10:1]};
	wire post_wrap = (post_cnt_q >= divisor - 11'h001);
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			main_psc_d1_q <= 1'b0;
			post_cnt_q <= 11'h000;
			post_clk_q <= 1'b0;
		end else begin
			main_psc_d1_q <= main_psc_clk;
			if (main_rise) begin
				post_cnt_q <= post_wrap ? 11'h000 : post_cnt_q + 11'h001;
				post_clk_q <= post_wrap | (post_cnt_q + 11'h001 < half_lo);
			end
		end
	end
	wire main_clk = cfg_q.post_divider_bypass ? main_psc_clk : post_clk_q;

	// ==========================================
	// Reference mux and control pin decoding
	wire ref_pd_mode = cfg_q.ref_pin_powerdown_cfg;
	wire ref_off_mode = !cfg_q.ref_enable_mode && !cfg_q.ref_source_select && !ref_pd_mode;
	wire ref_mux_mode = !cfg_q.ref_enable_mode && cfg_q.ref_source_select && !ref_pd_mode;
	wire ref_sel = ref_mux_mode ? ref_pin : cfg_q.ref_source_select;
	wire ref_clk = ref_sel ? ref_psc_clk : master_q;
	wire pd_req = (ref_pin && (ref_pd_mode || ref_off_mode)) || (main_pin && cfg_q.main_pin_powerdown_cfg);
	wire ref_en_pin = !(cfg_q.ref_enable_mode && !ref_pd_mode && ref_pin);
	wire main_en_pin = !(!cfg_q.main_pin_powerdown_cfg && main_pin);

	// ==========================================
	// Power state and settle counter
	logic [`DODC_CNT_W-1:0] settle_q;
	wire settled = (settle_q == `DODC_SETTLE_CYCLES);
	always_comb begin
		state_d = state_q;
		case (state_q)
			DODC_ST_SETTLE: begin
				if (pd_req) begin
					state_d = DODC_ST_DOWN;
				end else if (settled) begin
					state_d = DODC_ST_RUN;
				end
			end
			DODC_ST_RUN: begin
				if (pd_req) begin
					state_d = DODC_ST_DOWN;
				end
			end
			default: begin
				if (!pd_req) begin
					state_d = DODC_ST_SETTLE;
				end
			end
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_q <= DODC_ST_SETTLE;
			settle_q <= '0;
		end else begin
			state_q <= state_d;
			if (state_q != DODC_ST_SETTLE) begin
				settle_q <= '0;
			end else if (!settled) begin
				settle_q <= settle_q + `DODC_CNT_W'(1);
			end
		end
	end
	wire run = (state_q == DODC_ST_RUN);
	wire ref_en = run && ref_en_pin && !ref_off_mode;
	wire main_en = run && main_en_pin;

	// ==========================================
	// Output gates and status
	logic ref_out;
	logic ref_oe;
	logic main_out;
	logic main_oe;
	dodc_gate u_ref_gate (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_in(ref_clk),
		.enable(ref_en),
		.pin_out(ref_out),
		.pin_oe(ref_oe)
	);
	dodc_gate u_main_gate (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_in(main_clk),
		.enable(main_en),
		.pin_out(main_out),
		.pin_oe(main_oe)
	);
	assign clk_pins = '{ref_clk_out: ref_out, ref_clk_oe: ref_oe, main_clk_out: main_out, main_clk_oe: main_oe};

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			powered_down <= 1'b0;
		end else begin
			powered_down <= (state_d == DODC_ST_DOWN);
		end
	end
	assign cfg_rdata = cfg_q;
endmodule
`default_nettype wire

// File: tb/dodc_clk_sink.sv
`default_nettype none
// ====
// Downstream logic: rise-to-rise period of a driven clock pin
module dodc_clk_sink (
	// Clock
	input wire logic core_clk,
	// Observed pin
	input wire logic pin,
	input wire logic oe,
	// Period in cycles
	output var int period
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	logic last = 1'b0;
	initial period = 0;
	always @(posedge core_clk) begin
		cnt <= cnt + 1;
		last <= pin;
		if (oe && pin && !last) begin
			period <= cnt + 1;
			cnt <= 0;
		end
	end
endmodule
`default_nettype wire

// File: tb/dodc_monitor.sv
`default_nettype none
// ====
// Pin-level checks on the divider top
module dodc_monitor
	import dodc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Inputs
	input wire dodc_pkg::dodc_cfg_t cfg_wdata,
	input wire logic cfg_we,
	input wire logic ref_control_pin,
	input wire logic main_control_pin,
	// Outputs
	input wire dodc_pkg::dodc_out_t clk_pins,
	input wire logic powered_down,
	input wire dodc_pkg::dodc_cfg_t cfg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire logic any_oe = clk_pins.ref_clk_oe | clk_pins.main_clk_oe;
	property p_dflt;
		disable iff (1'b0) !rst_n |=> cfg_rdata.ref_enable_mode && cfg_rdata.ref_source_select
			&& !cfg_rdata.ref_pin_powerdown_cfg && !cfg_rdata.main_pin_powerdown_cfg;
	endproperty
	a_dflt: assert property (p_dflt) else $error("defaults not loaded");
	property p_take;
		cfg_we && !powered_down |=> cfg_rdata == $past(cfg_wdata);
	endproperty
	a_take: assert property (p_take) else $error("config not taken");
	property p_refuse;
		cfg_we && powered_down |=> $stable(cfg_rdata);
	endproperty
	a_refuse: assert property (p_refuse) else $error("config taken while down");
	property p_gate_m;
		$fell(clk_pins.main_clk_oe) |-> !$past(clk_pins.main_clk_out);
	endproperty
	a_gate_m: assert property (p_gate_m) else $error("main cut while high");
	property p_gate_r;
		$fell(clk_pins.ref_clk_oe) |-> !$past(clk_pins.ref_clk_out);
	endproperty
	a_gate_r: assert property (p_gate_r) else $error("ref cut while high");
	property p_main_en;
		!cfg_rdata.main_pin_powerdown_cfg && $rose(main_control_pin) |-> ##[1:40] !clk_pins.main_clk_oe && !powered_down;
	endproperty
	a_main_en: assert property (p_main_en) else $error("main enable wrong");
	property p_pd1;
		cfg_rdata.main_pin_powerdown_cfg && main_control_pin [*4] |-> ##[0:4] powered_down;
	endproperty
	a_pd1: assert property (p_pd1) else $error("main pin no power-down");
	property p_pd0;
		cfg_rdata.ref_pin_powerdown_cfg && ref_control_pin [*4] |-> ##[0:4] powered_down;
	endproperty
	a_pd0: assert property (p_pd0) else $error("ref pin no power-down");
	property p_float;
		$rose(powered_down) |-> ##[0:40] !any_oe;
	endproperty
	a_float: assert property (p_float) else $error("outputs not floated");
endmodule
`default_nettype wire

// File: tb/dual_output_clock_divider_control_tb_top.sv
`default_nettype none
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s exp %0d got %0d", nm, e, a); end end
// ====
// Top bench
module dual_output_clock_divider_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import dodc_pkg::*;
	typedef struct {logic [1:0] rp; logic [1:0] mp; logic byp; logic [9:0] n; int rper; int mper;} dodc_row_t;
	dodc_row_t rows [5] = '{'{2'h0, 2'h0, 1'b1, 10'h000, 2, 2}, '{2'h1, 2'h2, 1'b0, 10'h000, 4, 16},
		'{2'h0, 2'h0, 1'b0, 10'h3ff, 2, 2050}, '{2'h2, 2'h3, 1'b1, 10'h005, 8, 16}, '{2'h3, 2'h1, 1'b0, 10'h001, 16, 12}};
	logic core_clk = 0, rst_n = 0, cfg_we = 0, ref_pin = 0, main_pin = 0, powered_down;
	dodc_cfg_t cfg_wdata = '0, cfg_rdata, c;
	dodc_out_t clk_pins;
	int n_fail = 0, check_count = 0, ref_per, main_per, k;
	always #20 core_clk = ~core_clk;
	dodc_top dut (.core_clk(core_clk), .rst_n(rst_n), .cfg_wdata(cfg_wdata), .cfg_we(cfg_we),
		.ref_control_pin(ref_pin), .main_control_pin(main_pin), .clk_pins(clk_pins),
		.powered_down(powered_down), .cfg_rdata(cfg_rdata));
	dodc_clk_sink u_rs (.core_clk(core_clk), .pin(clk_pins.ref_clk_out), .oe(clk_pins.ref_clk_oe), .period(ref_per));
	dodc_clk_sink u_ms (.core_clk(core_clk), .pin(clk_pins.main_clk_out), .oe(clk_pins.main_clk_oe), .period(main_per));
	task wrap_up;
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task wcfg(input dodc_cfg_t v);
		@(negedge core_clk);
		cfg_wdata = v;
		cfg_we = 1'b1;
		@(negedge core_clk);
		cfg_we = 1'b0;
	endtask
	task wait_oe(input int sel, input int lim);
		for (int i = 0; i < lim; i++) begin
			@(negedge core_clk);
			if ((sel ? clk_pins.main_clk_oe : clk_pins.ref_clk_oe) === 1'b1) return;
		end
		$display("CHECK FAILED oe wait exp 1 got 0");
		n_fail++;
		wrap_up();
	endtask
	initial begin
		c = '0;
		c.ref_enable_mode = 1'b1;
		c.ref_source_select = 1'b1;
		repeat (8) @(negedge core_clk);
		`CHK("cfg dflt", c, cfg_rdata)
		`CHK("oe rst", 2'b00, {clk_pins.ref_clk_oe, clk_pins.main_clk_oe})
		rst_n = 1'b1;
		repeat (7990) @(negedge core_clk);
		`CHK("oe settle", 2'b00, {clk_pins.ref_clk_oe, clk_pins.main_clk_oe})
		wait_oe(0, 100);
		wait_oe(1, 100);
		$display("test settle done");
		foreach (rows[i]) begin
			c.ref_prescale_sel = rows[i].rp;
			c.main_prescale_sel = rows[i].mp;
			c.post_divider_bypass = rows[i].byp;
			c.post_div = rows[i].n;
			wcfg(c);
			`CHK("cfg", c, cfg_rdata)
			repeat (3 * rows[i].mper + 40) @(negedge core_clk);
			`CHK("ref per", rows[i].rper, ref_per)
			`CHK("main per", rows[i].mper, main_per)
			$display("test row %0d done", i);
		end
		main_pin = 1'b1;
		repeat (40) @(negedge core_clk);
		`CHK("main en", 3'b010, {powered_down, clk_pins.ref_clk_oe, clk_pins.main_clk_oe})
		ref_pin = 1'b1;
		repeat (40) @(negedge core_clk);
		`CHK("ref en", 1'b0, clk_pins.ref_clk_oe)
		{ref_pin, main_pin} = 2'b00;
		wait_oe(0, 60);
		wait_oe(1, 60);
		c.ref_enable_mode = 1'b0;
		wcfg(c);
		repeat (60) @(negedge core_clk);
		`CHK("mux lo", 2, ref_per)
		ref_pin = 1'b1;
		repeat (60) @(negedge core_clk);
		`CHK("mux hi", 16, ref_per)
		ref_pin = 1'b0;
		c.ref_source_select = 1'b0;
		wcfg(c);
		repeat (40) @(negedge core_clk);
		`CHK("zero mode", 2'b01, {clk_pins.ref_clk_oe, clk_pins.main_clk_oe})
		ref_pin = 1'b1;
		repeat (10) @(negedge core_clk);
		`CHK("zero pd", 1'b1, powered_down)
		wcfg(c ^ 19'h00001);
		`CHK("refused", c, cfg_rdata)
		ref_pin = 1'b0;
		wait_oe(1, 8100);
		$display("test modes done");
		c.ref_enable_mode = 1'b1;
		c.ref_source_select = 1'b1;
		c.ref_pin_powerdown_cfg = 1'b1;
		c.main_pin_powerdown_cfg = 1'b1;
		wcfg(c);
		for (k = 0; k < 2; k++) begin
			{ref_pin, main_pin} = k ? 2'b10 : 2'b01;
			repeat (40) @(negedge core_clk);
			`CHK("pd", 3'b100, {powered_down, clk_pins.ref_clk_oe, clk_pins.main_clk_oe})
			{ref_pin, main_pin} = 2'b00;
			wait_oe(0, 8100);
			`CHK("awake", 1'b0, powered_down)
		end
		$display("test power-down done");
		wrap_up();
	end
endmodule
bind dodc_top dodc_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n), .cfg_wdata(cfg_wdata), .cfg_we(cfg_we),
	.ref_control_pin(ref_control_pin), .main_control_pin(main_control_pin), .clk_pins(clk_pins),
	.powered_down(powered_down), .cfg_rdata(cfg_rdata));
`default_nettype wire
